//--- testbench/pmwc_far_model.sv
`timescale 1ns/1ps
`include "pmwc_defines.svh"
module pmwc_far_model (
  input  wire logic                    core_clk_i,
  output logic                         irq_req_o,
  output logic                         ext_irq_o,
  output logic                         dbg_cmd_o,
  output logic                         dbg_strobe_o,
  output logic                         rx_o,
  output logic                         byte_gap_o,
  output logic [`PMWC_GPIO_W-1:0]      gpio_o
);
  // The strobe is open-collector with a pull-up and the receive line
  // idles high, so both rest at one between events.
  initial begin
    irq_req_o    = 1'b0;
    ext_irq_o    = 1'b0;
    dbg_cmd_o    = 1'b0;
    dbg_strobe_o = 1'b1;
    rx_o         = 1'b1;
    byte_gap_o   = 1'b0;
    gpio_o       = 17'h00000;
  end

  // Level requests are held three cycles so a wake is never missed.
  task automatic act(input int sel);
    @(posedge core_clk_i);
    case (sel)
      0: irq_req_o <= 1'b1;
      1: ext_irq_o <= 1'b1;
      2: dbg_cmd_o <= 1'b1;
      3: dbg_strobe_o <= 1'b0;
      4: rx_o <= 1'b0;
      default: gpio_o <= gpio_o ^ 17'h00001;
    endcase
    fork
      begin
        repeat (3) @(posedge core_clk_i);
        irq_req_o    <= 1'b0;
        ext_irq_o    <= 1'b0;
        dbg_cmd_o    <= 1'b0;
        dbg_strobe_o <= 1'b1;
        rx_o         <= 1'b1;
      end
    join_none
  endtask

  task automatic gap();
    @(posedge core_clk_i);
    byte_gap_o <= 1'b1;
    @(posedge core_clk_i);
    byte_gap_o <= 1'b0;
  endtask
endmodule // pmwc_far_model

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "pmwc_defines.svh"
module tb
  import pmwc_pkg::*;
;
  logic                    core_clk_i = 1'b0;
  logic                    srst_i     = 1'b1;
  logic [`PMWC_ADDR_W-1:0] addr_i     = 8'h00;
  logic [`PMWC_DATA_W-1:0] wdata_i    = 32'h0;
  logic                    wr_i       = 1'b0;
  logic                    rd_i       = 1'b0;
  logic [`PMWC_DATA_W-1:0] rdata_o;
  logic                    irq_req, ext_irq, dbg_cmd, dbg_strobe;
  logic                    rx, byte_gap;
  logic [`PMWC_GPIO_W-1:0] gpio;
  logic                    core_halt_o, core_pwr_en_o, periph_clk_en_o;
  logic                    retain_pwr_o, serial_rx_en_o, serial_rst_o;
  logic                    irq_o;
  int                      error_cnt = 0;
  int                      cmp_count = 0;
  int                      cyc       = 0;

  pmwc_top pmwc_top_i (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_req_i(irq_req), .ext_irq_i(ext_irq), .dbg_wake_cmd_i(dbg_cmd),
    .dbg_load_strobe_i(dbg_strobe), .serial_rx_i(rx),
    .serial_byte_gap_i(byte_gap), .gpio_i(gpio),
    .core_halt_o(core_halt_o), .core_pwr_en_o(core_pwr_en_o),
    .periph_clk_en_o(periph_clk_en_o), .retain_pwr_o(retain_pwr_o),
    .serial_rx_en_o(serial_rx_en_o), .serial_rst_o(serial_rst_o),
    .irq_o(irq_o)
  );

  pmwc_far_model pmwc_far_model_i (
    .core_clk_i(core_clk_i), .irq_req_o(irq_req), .ext_irq_o(ext_irq),
    .dbg_cmd_o(dbg_cmd), .dbg_strobe_o(dbg_strobe), .rx_o(rx),
    .byte_gap_o(byte_gap), .gpio_o(gpio)
  );

  always #5 core_clk_i = ~core_clk_i;

  // The whole run needs well under a thousand cycles.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Counts edges until the core runs again, bounded against a hang.
  task automatic wake_wait(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
    end while (core_halt_o !== 1'b0 && n < 60);
  endtask

  task automatic serial_check();
    logic [31:0] v;
    chk("rx held off", 1'b0, serial_rx_en_o);
    rd(`PMWC_ADDR_STATUS, v);
    chk("rx wait status", 32'h21, v);
    pmwc_far_model_i.gap();
    #1 chk("serial reset", 1'b1, serial_rst_o);
    @(posedge core_clk_i);
    #1 chk("rx enabled", 1'b1, serial_rx_en_o);
    chk("reset pulse", 1'b0, serial_rst_o);
  endtask

  logic [31:0] rst_val [6] = '{32'h0, 32'hFFFF, 32'h11, 32'h0, 32'h0, 32'h0};
  int          idle_src [3] = '{0, 2, 3};
  int          dsel [5] = '{6, 1, 3, 4, 5};
  logic [31:0] dctl [5] = '{32'h12, 32'h02, 32'h02, 32'h06, 32'h0A};
  logic [31:0] dbit [5] = '{32'h02, 32'h04, 32'h08, 32'h10, 32'h20};
  int          dlo  [5] = '{22, 17, 17, 17, 17};

  initial begin
    logic [31:0] v;
    int          n;
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    #1 chk("halt", 1'b0, core_halt_o);
    chk("retain", 1'b1, retain_pwr_o);
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4), v);
      chk("reset value", rst_val[i], v);
    end
    $display("test reset done");
    foreach (idle_src[k]) begin
      wr(`PMWC_ADDR_CTRL, 32'h1);
      #1 chk("idle halt", 1'b1, core_halt_o);
      chk("idle periph", 1'b1, periph_clk_en_o);
      rd(`PMWC_ADDR_STATUS, v);
      chk("idle state", PMWC_ST_IDLE, v[2:0]);
      pmwc_far_model_i.act(idle_src[k]);
      wake_wait(n);
      chk("idle wake time", 1'b1, n <= 3);
      rd(`PMWC_ADDR_STATUS, v);
      chk("active state", PMWC_ST_ACTIVE, v[2:0]);
      rd(`PMWC_ADDR_INT_STAT, v);
      chk("idle flag", 1'b1, v[0]);
      chk("masked irq", 1'b0, irq_o);
      wr(`PMWC_ADDR_INT_STAT, 32'h3F);
    end
    $display("test idle done");
    wr(`PMWC_ADDR_INT_MASK, 32'h3F);
    wr(`PMWC_ADDR_INTERVAL, 32'h5);
    rd(`PMWC_ADDR_INT_MASK, v);
    chk("mask", 32'h3F, v);
    foreach (dsel[k]) begin
      wr(`PMWC_ADDR_CTRL, dctl[k]);
      #1 chk("deep halt", 1'b1, core_halt_o);
      chk("deep power", 1'b0, core_pwr_en_o);
      chk("deep periph", 1'b0, periph_clk_en_o);
      chk("deep retain", 1'b1, retain_pwr_o);
      chk("deep rx", 1'b0, serial_rx_en_o);
      if (dsel[k] < 6) pmwc_far_model_i.act(dsel[k]);
      wake_wait(n);
      chk("wake time", 1'b1, n >= dlo[k] && n <= dlo[k] + 4);
      chk("power back", 1'b1, core_pwr_en_o);
      rd(`PMWC_ADDR_INT_STAT, v);
      chk("wake flag", dbit[k], v);
      chk("irq raised", 1'b1, irq_o);
      if (dsel[k] == 4) serial_check();
      wr(`PMWC_ADDR_INT_STAT, 32'h3F);
      @(posedge core_clk_i);
      #1 chk("irq cleared", 1'b0, irq_o);
    end
    $display("test deep done");
    // Leave a serial wake pending its byte gap, then sleep again: the gap
    // must reset the port without reopening reception while asleep.
    wr(`PMWC_ADDR_CTRL, 32'h6);
    pmwc_far_model_i.act(4);
    wake_wait(n);
    chk("serial rewake", 1'b0, core_halt_o);
    wr(`PMWC_ADDR_CTRL, 32'h2);
    pmwc_far_model_i.act(4);
    pmwc_far_model_i.act(5);
    wr(`PMWC_ADDR_CTRL, 32'h1);
    pmwc_far_model_i.gap();
    @(posedge core_clk_i);
    #1 chk("rx kept off", 1'b0, serial_rx_en_o);
    repeat (25) @(posedge core_clk_i);
    #1 chk("no wake", 1'b1, core_halt_o);
    chk("still deep", 1'b0, core_pwr_en_o);
    pmwc_far_model_i.act(1);
    wake_wait(n);
    chk("ext wake", 1'b0, core_halt_o);
    chk("rx after wake", 1'b1, serial_rx_en_o);
    $display("test refusal done");
    give_verdict();
  end
endmodule // tb

//--- verilog/pmwc_defines.svh
`ifndef PMWC_DEFINES_SVH
`define PMWC_DEFINES_SVH

// Register byte addresses.
`define PMWC_ADDR_CTRL      8'h00
`define PMWC_ADDR_INTERVAL  8'h04
`define PMWC_ADDR_STATUS    8'h08
`define PMWC_ADDR_INT_STAT  8'h0C
`define PMWC_ADDR_INT_MASK  8'h10

// Control register fields.
`define PMWC_CTRL_GO_IDLE   0
`define PMWC_CTRL_GO_DEEP   1
`define PMWC_CTRL_SER_EN    2
`define PMWC_CTRL_GPIO_EN   3
`define PMWC_CTRL_TMR_EN    4

// Interrupt status and mask fields.
`define PMWC_EVT_IDLE_WAKE  0
`define PMWC_EVT_TIMER      1
`define PMWC_EVT_EXT_IRQ    2
`define PMWC_EVT_DEBUG      3
`define PMWC_EVT_SERIAL     4
`define PMWC_EVT_GPIO       5
`define PMWC_EVT_W          6

// Status register fields.
`define PMWC_STAT_STATE_LO  0
`define PMWC_STAT_STATE_HI  2
`define PMWC_STAT_WAKING    3
`define PMWC_STAT_RX_EN     4
`define PMWC_STAT_RX_WAIT   5

// Widths, reset values and timing.
`define PMWC_ADDR_W         8
`define PMWC_DATA_W         32
`define PMWC_GPIO_W         17
`define PMWC_TMR_W          16
`define PMWC_CNT_W          8
`define PMWC_WAKE_CYCLES    8'h10
`define PMWC_INTERVAL_RST   16'hFFFF
`define PMWC_CTRL_RST       5'h00
`define PMWC_EVT_ZERO       6'h00

`endif

//--- verilog/pmwc_pkg.sv
package pmwc_pkg;

  typedef enum logic [2:0] {
    PMWC_ST_ACTIVE = 3'b001,
    PMWC_ST_IDLE   = 3'b010,
    PMWC_ST_DEEP   = 3'b100
  } pmwc_state_t;

  typedef logic [5:0] pmwc_evt_t;

endpackage

//--- verilog/pmwc_top.sv
`timescale 1ns/1ps
`include "pmwc_defines.svh"
// Function
// - Exactly three states: active, idle, deep sleep.
// - Idle halts core until interrupt or debug wake.
// - Idle keeps peripheral power and clocks running.
// - Deep sleep cuts logic power, retains pads, RAM.
// - Deep wake on timer, external interrupt, debug.
// - Serial wake optional; reception blocked until awake.
// - After serial wake, reset port between bytes.
// - Gpio activity optionally wakes from deep sleep.
// - Debug load strobe edge wakes idle or deep.
module pmwc_top
  import pmwc_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    srst_i,
  input  wire logic [`PMWC_ADDR_W-1:0] addr_i,
  input  wire logic [`PMWC_DATA_W-1:0] wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [`PMWC_DATA_W-1:0] rdata_o,
  input  wire logic                    irq_req_i,
  input  wire logic                    ext_irq_i,
  input  wire logic                    dbg_wake_cmd_i,
  input  wire logic                    dbg_load_strobe_i,
  input  wire logic                    serial_rx_i,
  input  wire logic                    serial_byte_gap_i,
  input  wire logic [`PMWC_GPIO_W-1:0] gpio_i,
  output logic                         core_halt_o,
  output logic                         core_pwr_en_o,
  output logic                         periph_clk_en_o,
  output logic                         retain_pwr_o,
  output logic                         serial_rx_en_o,
  output logic                         serial_rst_o,
  output logic                         irq_o
);

  pmwc_wake_if wk ();

  pmwc_state_t             state_r;
  pmwc_state_t             state_nxt;
  logic                    waking_r;
  logic                    waking_nxt;
  logic [`PMWC_CNT_W-1:0]  wake_cnt_r;
  logic [`PMWC_TMR_W-1:0]  timer_cnt_r;
  logic [`PMWC_TMR_W-1:0]  interval_r;
  logic                    ser_en_r;
  logic                    gpio_en_r;
  logic                    tmr_en_r;
  logic                    ser_woke_r;
  logic                    rx_wait_r;
  pmwc_evt_t               int_stat_r;
  pmwc_evt_t               int_stat_nxt;
  pmwc_evt_t               int_mask_r;
  pmwc_evt_t               evt_set;
  pmwc_evt_t               deep_src;
  logic                    idle_wake;
  logic                    timer_hit;
  logic                    deep_start;
  logic                    wake_done;
  logic                    go_idle;
  logic                    go_deep;

  // Register write decode, shared by every write-side process.
  function automatic logic wr_hit(input logic [`PMWC_ADDR_W-1:0] a);
    return wr_i && (addr_i == a);
  endfunction

  pmwc_wake_detect u_detect (
    .core_clk_i        (core_clk_i),
    .srst_i            (srst_i),
    .dbg_load_strobe_i (dbg_load_strobe_i),
    .serial_rx_i       (serial_rx_i),
    .gpio_i            (gpio_i),
    .wk                (wk)
  );

  assign go_idle = wr_hit(`PMWC_ADDR_CTRL) && wdata_i[`PMWC_CTRL_GO_IDLE];
  assign go_deep = wr_hit(`PMWC_ADDR_CTRL) && wdata_i[`PMWC_CTRL_GO_DEEP];

  assign timer_hit = tmr_en_r && (timer_cnt_r == '0);

  always_comb begin
    deep_src                      = `PMWC_EVT_ZERO;
    deep_src[`PMWC_EVT_TIMER]     = timer_hit;
    deep_src[`PMWC_EVT_EXT_IRQ]   = ext_irq_i;
    deep_src[`PMWC_EVT_DEBUG]     = wk.dbg_edge;
    deep_src[`PMWC_EVT_SERIAL]    = ser_en_r && wk.ser_act;
    deep_src[`PMWC_EVT_GPIO]      = gpio_en_r && wk.gpio_act;
  end

  assign idle_wake  = irq_req_i || dbg_wake_cmd_i || wk.dbg_edge;
  assign deep_start = (state_r == PMWC_ST_DEEP) && !waking_r
                      && (deep_src != `PMWC_EVT_ZERO);
  assign wake_done  = waking_r && (wake_cnt_r == '0);

  // Only three codes are legal; a corrupted code falls back to active.
  always_comb begin
    state_nxt  = state_r;
    waking_nxt = waking_r;
    unique case (state_r)
      PMWC_ST_ACTIVE: begin
        if (go_deep) begin
          state_nxt = PMWC_ST_DEEP;
        end else if (go_idle) begin
          state_nxt = PMWC_ST_IDLE;
        end
      end
      PMWC_ST_IDLE: begin
        if (idle_wake) begin
          state_nxt = PMWC_ST_ACTIVE;
        end
      end
      PMWC_ST_DEEP: begin
        if (deep_start) begin
          waking_nxt = 1'b1;
        end else if (wake_done) begin
          waking_nxt = 1'b0;
          state_nxt  = PMWC_ST_ACTIVE;
        end
      end
      default: begin
        state_nxt  = PMWC_ST_ACTIVE;
        waking_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r  <= PMWC_ST_ACTIVE;
      waking_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      waking_r <= waking_nxt;
    end
  end

  // Wake-up sequence length, standing in for supply and clock settling.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wake_cnt_r <= '0;
    end else if (deep_start) begin
      wake_cnt_r <= `PMWC_WAKE_CYCLES - `PMWC_CNT_W'(1);
    end else if (waking_r && (wake_cnt_r != '0)) begin
      wake_cnt_r <= wake_cnt_r - `PMWC_CNT_W'(1);
    end
  end

  // The sleep timer is reloaded while active and runs down only in deep sleep.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      timer_cnt_r <= `PMWC_INTERVAL_RST;
    end else if (state_r == PMWC_ST_ACTIVE) begin
      timer_cnt_r <= interval_r;
    end else if ((state_r == PMWC_ST_DEEP) && !waking_r
                 && (timer_cnt_r != '0)) begin
      timer_cnt_r <= timer_cnt_r - `PMWC_TMR_W'(1);
    end
  end

  // Power and clock controls follow the next state so they change in the
  // same cycle as the state register.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      core_halt_o     <= 1'b0;
      core_pwr_en_o   <= 1'b1;
      periph_clk_en_o <= 1'b1;
      retain_pwr_o    <= 1'b1;
    end else begin
      core_halt_o     <= state_nxt != PMWC_ST_ACTIVE;
      core_pwr_en_o   <= (state_nxt != PMWC_ST_DEEP) || waking_nxt;
      periph_clk_en_o <= state_nxt != PMWC_ST_DEEP;
      retain_pwr_o    <= 1'b1;
    end
  end

  // A byte may still be on the wire when the wake sequence ends, so after
  // a serial wake the port is reset only at a byte gap.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      serial_rx_en_o <= 1'b1;
      serial_rst_o   <= 1'b0;
      ser_woke_r     <= 1'b0;
      rx_wait_r      <= 1'b0;
    end else begin
      serial_rst_o <= 1'b0;
      if (state_nxt == PMWC_ST_DEEP) begin
        serial_rx_en_o <= 1'b0;
      end
      if (deep_start && deep_src[`PMWC_EVT_SERIAL]) begin
        ser_woke_r <= 1'b1;
      end
      if (wake_done) begin
        if (ser_woke_r) begin
          rx_wait_r <= 1'b1;
        end else begin
          serial_rx_en_o <= 1'b1;
        end
      end
      if (rx_wait_r && serial_byte_gap_i) begin
        serial_rst_o <= 1'b1;
        rx_wait_r    <= 1'b0;
        ser_woke_r   <= 1'b0;
      end
      if (serial_rst_o && (state_nxt != PMWC_ST_DEEP)) begin
        serial_rx_en_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ser_en_r   <= 1'b0;
      gpio_en_r  <= 1'b0;
      tmr_en_r   <= 1'b0;
      interval_r <= `PMWC_INTERVAL_RST;
      int_mask_r <= `PMWC_EVT_ZERO;
    end else begin
      if (wr_hit(`PMWC_ADDR_CTRL)) begin
        ser_en_r  <= wdata_i[`PMWC_CTRL_SER_EN];
        gpio_en_r <= wdata_i[`PMWC_CTRL_GPIO_EN];
        tmr_en_r  <= wdata_i[`PMWC_CTRL_TMR_EN];
      end
      if (wr_hit(`PMWC_ADDR_INTERVAL)) begin
        interval_r <= wdata_i[`PMWC_TMR_W-1:0];
      end
      if (wr_hit(`PMWC_ADDR_INT_MASK)) begin
        int_mask_r <= wdata_i[`PMWC_EVT_W-1:0];
      end
    end
  end

  // Sticky wake causes; a new cause beats a write-one-to-clear.
  always_comb begin
    evt_set = `PMWC_EVT_ZERO;
    if (deep_start) begin
      evt_set = deep_src;
    end
    if ((state_r == PMWC_ST_IDLE) && idle_wake) begin
      evt_set[`PMWC_EVT_IDLE_WAKE] = 1'b1;
    end
    int_stat_nxt = int_stat_r;
    if (wr_hit(`PMWC_ADDR_INT_STAT)) begin
      int_stat_nxt = int_stat_nxt & ~wdata_i[`PMWC_EVT_W-1:0];
    end
    int_stat_nxt = int_stat_nxt | evt_set;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      int_stat_r <= `PMWC_EVT_ZERO;
      irq_o      <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      irq_o      <= (int_stat_nxt & int_mask_r) != `PMWC_EVT_ZERO;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= '0;
      if (rd_i) begin
        unique case (addr_i)
          `PMWC_ADDR_CTRL: begin
            rdata_o[`PMWC_CTRL_SER_EN]  <= ser_en_r;
            rdata_o[`PMWC_CTRL_GPIO_EN] <= gpio_en_r;
            rdata_o[`PMWC_CTRL_TMR_EN]  <= tmr_en_r;
          end
          `PMWC_ADDR_INTERVAL: begin
            rdata_o[`PMWC_TMR_W-1:0] <= interval_r;
          end
          `PMWC_ADDR_STATUS: begin
            rdata_o[`PMWC_STAT_STATE_HI:`PMWC_STAT_STATE_LO] <= state_r;
            rdata_o[`PMWC_STAT_WAKING]  <= waking_r;
            rdata_o[`PMWC_STAT_RX_EN]   <= serial_rx_en_o;
            rdata_o[`PMWC_STAT_RX_WAIT] <= rx_wait_r;
          end
          `PMWC_ADDR_INT_STAT: begin
            rdata_o[`PMWC_EVT_W-1:0] <= int_stat_r;
          end
          `PMWC_ADDR_INT_MASK: begin
            rdata_o[`PMWC_EVT_W-1:0] <= int_mask_r;
          end
          default: begin
            rdata_o <= '0;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  chk_state_onehot: assert property (
    $onehot(state_r))
    else $error("power state is not one of the three legal codes");

  chk_idle_resume: assert property (
    (state_r == PMWC_ST_IDLE) && irq_req_i
    |=> (state_r == PMWC_ST_ACTIVE) && !core_halt_o)
    else $error("interrupt in idle did not resume the core");

  chk_idle_periph_on: assert property (
    (state_r == PMWC_ST_IDLE)
    |-> periph_clk_en_o && core_pwr_en_o && core_halt_o)
    else $error("idle must halt core but keep peripherals running");

  chk_deep_power_off: assert property (
    (state_r == PMWC_ST_DEEP) && !waking_r
    |-> !core_pwr_en_o && !periph_clk_en_o && retain_pwr_o)
    else $error("deep sleep power controls are wrong");

  chk_timer_wake: assert property (
    (state_r == PMWC_ST_DEEP) && !waking_r && timer_hit
    |=> waking_r && int_stat_r[`PMWC_EVT_TIMER])
    else $error("sleep timer expiry did not start wake-up");

  chk_rx_blocked: assert property (
    (state_r == PMWC_ST_DEEP) || rx_wait_r |-> !serial_rx_en_o)
    else $error("serial reception enabled before wake-up finished");

  chk_rx_flush: assert property (
    rx_wait_r && serial_byte_gap_i
    |=> serial_rst_o && !serial_rx_en_o
        ##1 (serial_rx_en_o || (state_r == PMWC_ST_DEEP)) && !serial_rst_o)
    else $error("serial port not reset at byte gap after wake");

  chk_gpio_wake: assert property (
    (state_r == PMWC_ST_DEEP) && !waking_r && gpio_en_r && wk.gpio_act
    |=> waking_r && int_stat_r[`PMWC_EVT_GPIO])
    else $error("gpio activity did not wake from deep sleep");

  chk_debug_wake: assert property (
    (state_r == PMWC_ST_DEEP) && !waking_r && wk.dbg_edge
    |=> waking_r ##16 (state_r == PMWC_ST_ACTIVE))
    else $error("debug strobe edge did not wake within the sequence");

  chk_wake_return: assert property (
    wake_done
    |=> (state_r == PMWC_ST_ACTIVE) && !core_halt_o && core_pwr_en_o
        && periph_clk_en_o)
    else $error("wake-up did not return the core to active");

  cov_idle_wake: cover property (
    (state_r == PMWC_ST_IDLE) ##1 (state_r == PMWC_ST_ACTIVE));

  cov_serial_wake: cover property (
    deep_start && deep_src[`PMWC_EVT_SERIAL] ##[1:200] serial_rst_o);

  cov_timer_wake: cover property (
    deep_start && deep_src[`PMWC_EVT_TIMER]);

  cov_irq_raised: cover property (!irq_o ##1 irq_o);

endmodule // pmwc_top

//--- verilog/pmwc_wake_detect.sv
`timescale 1ns/1ps
`include "pmwc_defines.svh"
module pmwc_wake_detect
  import pmwc_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    srst_i,
  input  wire logic                    dbg_load_strobe_i,
  input  wire logic                    serial_rx_i,
  input  wire logic [`PMWC_GPIO_W-1:0] gpio_i,
  pmwc_wake_if.det                     wk
);

  logic                    primed_r;
  logic                    strobe_d_r;
  logic                    rx_d_r;
  logic [`PMWC_GPIO_W-1:0] gpio_d_r;

  // The first sample after reset only primes the history, so a pin that
  // merely rests high is never mistaken for activity.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      primed_r <= 1'b0;
    end else begin
      primed_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      strobe_d_r <= 1'b1;
      rx_d_r     <= 1'b1;
      gpio_d_r   <= '0;
    end else begin
      strobe_d_r <= dbg_load_strobe_i;
      rx_d_r     <= serial_rx_i;
      gpio_d_r   <= gpio_i;
    end
  end

  // Either edge of the load strobe counts; any gpio change counts.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wk.dbg_edge <= 1'b0;
      wk.gpio_act <= 1'b0;
      wk.ser_act  <= 1'b0;
    end else begin
      wk.dbg_edge <= primed_r && (strobe_d_r != dbg_load_strobe_i);
      wk.gpio_act <= primed_r && (gpio_d_r != gpio_i);
      wk.ser_act  <= primed_r && (rx_d_r != serial_rx_i);
    end
  end

endmodule // pmwc_wake_detect

//--- verilog/pmwc_wake_if.sv
`timescale 1ns/1ps
interface pmwc_wake_if;
  logic dbg_edge;
  logic gpio_act;
  logic ser_act;

  modport det (
    output dbg_edge,
    output gpio_act,
    output ser_act
  );

  modport ctl (
    input dbg_edge,
    input gpio_act,
    input ser_act
  );
endinterface
